// file: logic/c4rsb_pkg.sv
// Purpose: Shared constants and types for the 4-bit core return/skip/bit-op slice.
// Assumes: 10-bit instruction words, 4-bit data nibbles, one clock domain.
// Notes: Opcodes are full 10-bit codes; the bit-set word and the compare's second word hold data.
package c4rsb_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [9:0] OP_CLR_CARRY = 10'h006;
  localparam logic [9:0] OP_SET_CARRY = 10'h007;
  localparam logic [9:0] OP_CLR_LINE = 10'h014;
  localparam logic [9:0] OP_SET_LINE = 10'h015;
  localparam logic [9:0] OP_RET_SUB = 10'h044;
  localparam logic [9:0] OP_RET_SKIP = 10'h045;
  localparam logic [9:0] OP_RET_IRQ = 10'h046;
  localparam logic [9:0] OP_SET_BIT = 10'h05C;
  localparam logic [9:0] OP_SKIP_IMM = 10'h025;
  localparam logic [9:0] OP_SKIP_MEM = 10'h026;
  localparam logic [9:0] OP_EXT0_SKIP = 10'h038;
  localparam logic [9:0] OP_EXT1_SKIP = 10'h039;
  localparam logic [5:0] OP_IMM_WORD_HI = 6'h07;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int BIT_SEL_W = 2;
  localparam int IMM_W = 4;
  localparam int LINE_SEL_W = 3;
  localparam int NIB_W = 4;
  localparam int LINE_CNT = 8;
  localparam logic [NIB_W-1:0] LINE_Y_MAX = 4'h7;
  localparam int CYC_RET_SUB = 2;
  localparam logic [LINE_CNT-1:0] LINES_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BUSY,
    ST_IMM
  } c4rsb_state_t;

  // Context saved when an interrupt is taken and put back on return
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] breg;
    logic [3:0] xptr;
    logic [3:0] yptr;
    logic [1:0] zptr;
    logic carry;
    logic skip;
    logic load_suppress;
  } c4rsb_ctx_t;

endpackage : c4rsb_pkg

// file: logic/c4rsb_stack_mem.sv
// Purpose: Return-address stack storage with a registered read port.
// Assumes: Read address is the level that will hold on the next edge.
// Notes: A write to the address being read is forwarded to the read register.
`timescale 1ns/1ps
module c4rsb_stack_mem #(
  parameter int W = 14,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage and read register
  // ----------------------------------------------------------------
  // Forwarding keeps a push followed at once by a return correct
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (ce) begin
      if (we && waddr == raddr) begin
        rdata <= wdata;
      end else begin
        rdata <= mem[raddr];
      end
    end
  end

  // Array kept out of reset so it maps onto plain storage
  always_ff @(posedge core_clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

endmodule : c4rsb_stack_mem

// file: logic/c4rsb_core.sv
// Purpose: Executes carry, output-line, return, bit-set, compare-skip and flag-skip words.
// Assumes: All inputs come from logic on core_clk; pc increments happen elsewhere.
// Notes: A skipped word is consumed and discarded; a plain or skip return stalls one extra cycle, an interrupt return does not.
`timescale 1ns/1ps
// Function
// - Set-line word drives output line Y to 1 when Y is 0 to 7.
// - Interrupt return loads pc from stack top, drops level, one cycle.
// - Interrupt return restores pointers, carry, skip, load-suppress, A and B.
// - Return-with-skip pops like plain return then always skips next word.
// - Set-bit word writes 1 to bit j of the addressed memory nibble.
// - Two-word immediate compare skips next word when accumulator equals n.
// - Memory compare skips next word when accumulator equals the memory nibble.
// - With enable 0 clear, external-0 flag set causes a skip.
// - A skip from the external-0 test clears the external-0 flag.
// - With its enable set, a flag skip test neither skips nor clears.
// - With enable 1 clear, external-1 flag set causes a skip.
// - A skip from the external-1 test clears the external-1 flag.
module c4rsb_core #(
  parameter int PC_W = 14,
  parameter int STACK_DEPTH = 8,
  parameter int SL_W = 3
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  output logic instr_ready,
  input wire logic [3:0] acc_val,
  input wire logic [3:0] y_val,
  input wire logic [3:0] mem_rdata,
  output logic mem_we,
  output logic [3:0] mem_wdata,
  input wire logic call_push,
  input wire logic [PC_W-1:0] push_pc,
  input wire logic irq_taken,
  input wire c4rsb_pkg::c4rsb_ctx_t ctx_in,
  output logic ctx_restore,
  output c4rsb_pkg::c4rsb_ctx_t ctx_out,
  input wire logic ext0_event,
  input wire logic ext1_event,
  input wire logic ext0_irq_enable,
  input wire logic ext1_irq_enable,
  output logic ext0_request_flag,
  output logic ext1_request_flag,
  output logic carry_flag,
  output logic skip_pending,
  output logic [c4rsb_pkg::LINE_CNT-1:0] out_lines,
  output logic pc_load,
  output logic [PC_W-1:0] program_counter,
  output logic [SL_W-1:0] stack_level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    c4rsb_pkg::c4rsb_state_t st;
    logic carry;
    logic skip;
    logic ext0;
    logic ext1;
    logic [c4rsb_pkg::LINE_CNT-1:0] lines;
    logic [SL_W-1:0] level;
    logic [PC_W-1:0] pc;
    logic pc_load;
    logic mem_we;
    logic [3:0] mem_wdata;
    logic ctx_restore;
    c4rsb_pkg::c4rsb_ctx_t saved;
  } c4rsb_regs_t;
  c4rsb_regs_t state_reg;
  c4rsb_regs_t state_next;
  logic [PC_W-1:0] stack_top;
  logic take;
  logic exec;
  // Set one bit of a nibble, used by the bit-set word
  function automatic logic [3:0] set_bit(input logic [3:0] v, input logic [1:0] j);
    return v | (4'h1 << j);
  endfunction : set_bit
  // Output line select is only valid for Y up to 7
  function automatic logic line_ok(input logic [3:0] y);
    return y <= c4rsb_pkg::LINE_Y_MAX;
  endfunction : line_ok
  // Ready drops only in the second cycle of a plain or skip return
  assign instr_ready = (state_reg.st != c4rsb_pkg::ST_BUSY);
  assign take = ce && instr_valid && instr_ready;
  assign exec = take && !state_reg.skip;
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pc_load = 1'b0;
    state_next.mem_we = 1'b0;
    state_next.ctx_restore = 1'b0;
    if (state_reg.st == c4rsb_pkg::ST_BUSY) begin
      state_next.st = c4rsb_pkg::ST_IDLE;
    end
    if (take && state_reg.skip) begin
      state_next.skip = 1'b0; // Skipped word is swallowed whole
    end else if (exec && state_reg.st == c4rsb_pkg::ST_IMM) begin
      state_next.st = c4rsb_pkg::ST_IDLE;
      if (acc_val == instr_word[c4rsb_pkg::IMM_W-1:0]) begin
        state_next.skip = 1'b1;
      end
    end else if (exec) begin
      if (instr_word[9:c4rsb_pkg::BIT_SEL_W] == c4rsb_pkg::OP_SET_BIT[9:c4rsb_pkg::BIT_SEL_W])
      begin
        state_next.mem_we = 1'b1;
        state_next.mem_wdata = set_bit(mem_rdata, instr_word[c4rsb_pkg::BIT_SEL_W-1:0]);
      end
      case (instr_word)
        c4rsb_pkg::OP_CLR_CARRY: begin
          state_next.carry = 1'b0;
        end
        c4rsb_pkg::OP_SET_CARRY: begin
          state_next.carry = 1'b1;
        end
        c4rsb_pkg::OP_CLR_LINE: begin
          if (line_ok(y_val)) begin
            state_next.lines[y_val[c4rsb_pkg::LINE_SEL_W-1:0]] = 1'b0;
          end
        end
        c4rsb_pkg::OP_SET_LINE: begin
          if (line_ok(y_val)) begin
            state_next.lines[y_val[c4rsb_pkg::LINE_SEL_W-1:0]] = 1'b1;
          end
        end
        c4rsb_pkg::OP_RET_SUB, c4rsb_pkg::OP_RET_SKIP: begin
          state_next.pc = stack_top;
          state_next.pc_load = 1'b1;
          state_next.level = state_reg.level - 1'b1;
          state_next.st = c4rsb_pkg::ST_BUSY;
          state_next.skip = (instr_word == c4rsb_pkg::OP_RET_SKIP);
        end
        c4rsb_pkg::OP_RET_IRQ: begin
          state_next.pc = stack_top;
          state_next.pc_load = 1'b1;
          state_next.level = state_reg.level - 1'b1;
          state_next.ctx_restore = 1'b1;
          state_next.carry = state_reg.saved.carry;
          state_next.skip = state_reg.saved.skip;
        end
        c4rsb_pkg::OP_SKIP_IMM: begin
          state_next.st = c4rsb_pkg::ST_IMM;
        end
        c4rsb_pkg::OP_SKIP_MEM: begin
          state_next.skip = (acc_val == mem_rdata);
        end
        c4rsb_pkg::OP_EXT0_SKIP: begin
          // Enabled flag leaves the test a no-op
          if (!ext0_irq_enable && state_reg.ext0) begin
            state_next.skip = 1'b1;
            state_next.ext0 = 1'b0;
          end
        end
        c4rsb_pkg::OP_EXT1_SKIP: begin
          if (!ext1_irq_enable && state_reg.ext1) begin
            state_next.skip = 1'b1;
            state_next.ext1 = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // New request wins over a clear in the same cycle
    state_next.ext0 = state_next.ext0 | ext0_event;
    state_next.ext1 = state_next.ext1 | ext1_event;
    // A call pushes the return address one level up
    if (call_push) begin
      state_next.level = state_reg.level + 1'b1;
    end
    // Snapshot uses the live carry and skip, others come from ctx_in
    if (irq_taken) begin
      state_next.saved = ctx_in;
      state_next.saved.carry = state_reg.carry;
      state_next.saved.skip = state_reg.skip;
    end
  end
  // Whole state frozen while the clock enable is low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
      state_reg.st <= c4rsb_pkg::ST_IDLE;
      state_reg.lines <= c4rsb_pkg::LINES_RST;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end
  // ----------------------------------------------------------------
  // Return-address stack
  // ----------------------------------------------------------------
  // Read at the next level so the top is ready when a return arrives
  c4rsb_stack_mem #(
    .W(PC_W),
    .DEPTH(STACK_DEPTH),
    .AW(SL_W)
  ) u_stack (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .we(call_push),
    .waddr(state_next.level),
    .wdata(push_pc),
    .raddr(state_next.level),
    .rdata(stack_top)
  );
  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_we = state_reg.mem_we;
  assign mem_wdata = state_reg.mem_wdata;
  assign ctx_restore = state_reg.ctx_restore;
  assign ctx_out = state_reg.saved;
  assign ext0_request_flag = state_reg.ext0;
  assign ext1_request_flag = state_reg.ext1;
  assign carry_flag = state_reg.carry;
  assign skip_pending = state_reg.skip;
  assign out_lines = state_reg.lines;
  assign pc_load = state_reg.pc_load;
  assign program_counter = state_reg.pc;
  assign stack_level = state_reg.level;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_clr_line;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_CLR_LINE
      && !y_val[3] |=> out_lines[$past(y_val[2:0])] == 1'b0;
  endproperty
  a_clr_line: assert property (p_clr_line) else $error("line not cleared");
  property p_set_line;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_SET_LINE
      && !y_val[3] |=> out_lines[$past(y_val[2:0])] == 1'b1;
  endproperty
  a_set_line: assert property (p_set_line) else $error("line not set");
  property p_ret_sub;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_RET_SUB
      && !call_push |=> pc_load && program_counter == $past(stack_top)
      && stack_level == $past(stack_level) - 1'b1 && !instr_ready && !skip_pending
      ##1 instr_ready;
  endproperty
  a_ret_sub: assert property (p_ret_sub) else $error("plain return wrong");
  property p_ret_irq;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_RET_IRQ
      && !call_push |=> pc_load && ctx_restore && instr_ready
      && stack_level == $past(stack_level) - 1'b1 && program_counter == $past(stack_top);
  endproperty
  a_ret_irq: assert property (p_ret_irq) else $error("interrupt return wrong");
  property p_ctx;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_RET_IRQ
      |=> carry_flag == ctx_out.carry && skip_pending == ctx_out.skip;
  endproperty
  a_ctx: assert property (p_ctx) else $error("context not restored");
  property p_ret_skip;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_RET_SKIP
      |=> skip_pending && pc_load && !instr_ready;
  endproperty
  a_ret_skip: assert property (p_ret_skip) else $error("return skip missing");
  property p_set_bit;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word[9:2] == c4rsb_pkg::OP_SET_BIT[9:2]
      |=> mem_we && mem_wdata[$past(instr_word[1:0])] == 1'b1
      && (mem_wdata | (4'h1 << $past(instr_word[1:0]))) == ($past(mem_rdata)
      | (4'h1 << $past(instr_word[1:0])));
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit set wrong");
  property p_imm;
    exec && state_reg.st == c4rsb_pkg::ST_IMM |=> skip_pending == ($past(acc_val)
      == $past(instr_word[3:0]));
  endproperty
  a_imm: assert property (p_imm) else $error("immediate compare wrong");
  property p_mem;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_SKIP_MEM
      |=> skip_pending == ($past(acc_val) == $past(mem_rdata));
  endproperty
  a_mem: assert property (p_mem) else $error("memory compare wrong");
  property p_ext0;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_EXT0_SKIP
      && !ext0_irq_enable && ext0_request_flag && !ext0_event |=> skip_pending
      && !ext0_request_flag;
  endproperty
  a_ext0: assert property (p_ext0) else $error("ext0 skip wrong");
  property p_ext1_off;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_EXT1_SKIP
      && ext1_irq_enable |=> !skip_pending && ext1_request_flag == $past(ext1_request_flag)
      || $past(ext1_event);
  endproperty
  a_ext1_off: assert property (p_ext1_off) else $error("enabled test acted");
  property p_carry;
    exec && state_reg.st == c4rsb_pkg::ST_IDLE && instr_word == c4rsb_pkg::OP_SET_CARRY
      |=> carry_flag && out_lines == $past(out_lines) && instr_ready;
  endproperty
  a_carry: assert property (p_carry) else $error("carry set wrong");

endmodule : c4rsb_core

// file: bench/c4rsb_core_test.sv
// Purpose: Self-checking bench for the return, skip, bit and carry slice.
// Assumes: One word per issue; effects are checked at the negedge after the taking edge.
// Notes: A skip is proved by offering set-carry as the next word and seeing carry stay 0.
`timescale 1ns/1ps
module c4rsb_core_test;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic core_clk, nrst, ce, instr_valid, call_push, irq_taken;
  logic ext0_event, ext1_event, ext0_irq_enable, ext1_irq_enable;
  logic [9:0] instr_word;
  logic [3:0] acc_val, y_val, mem_rdata, mem_wdata;
  logic [13:0] push_pc, program_counter;
  c4rsb_pkg::c4rsb_ctx_t ctx_in, ctx_out;
  logic instr_ready, mem_we, ctx_restore, ext0_request_flag, ext1_request_flag;
  logic carry_flag, skip_pending, pc_load;
  logic [7:0] out_lines, lines_exp;
  logic [2:0] stack_level;
  int mismatches, comparisons;

  c4rsb_core i_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ready(instr_ready), .acc_val(acc_val), .y_val(y_val),
    .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata), .call_push(call_push),
    .push_pc(push_pc), .irq_taken(irq_taken), .ctx_in(ctx_in), .ctx_restore(ctx_restore),
    .ctx_out(ctx_out), .ext0_event(ext0_event), .ext1_event(ext1_event),
    .ext0_irq_enable(ext0_irq_enable), .ext1_irq_enable(ext1_irq_enable),
    .ext0_request_flag(ext0_request_flag), .ext1_request_flag(ext1_request_flag),
    .carry_flag(carry_flag), .skip_pending(skip_pending), .out_lines(out_lines),
    .pc_load(pc_load), .program_counter(program_counter), .stack_level(stack_level));

  // 100 ns period clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  // Offer one word, hold it until ready, return at the negedge after it was taken
  task automatic issue(input logic [9:0] w);
    int n;
    @(posedge core_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    n = 0;
    @(negedge core_clk);
    while (instr_ready !== 1'b1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 10) begin
      mismatches++;
      final_report();
    end
    @(posedge core_clk);
    instr_valid <= 1'b0;
    @(negedge core_clk);
  endtask : issue

  // Expects carry 0 on entry; a discarded set-carry word leaves it 0
  task automatic probe_skip(input string what, input logic exp);
    check(what, skip_pending, exp);
    issue(c4rsb_pkg::OP_SET_CARRY);
    check("carry after skip window", carry_flag, !exp);
    issue(c4rsb_pkg::OP_CLR_CARRY);
  endtask : probe_skip

  task automatic push(input logic [13:0] pc);
    @(posedge core_clk);
    call_push <= 1'b1;
    push_pc <= pc;
    @(posedge core_clk);
    call_push <= 1'b0;
    @(negedge core_clk);
  endtask : push

  task automatic set_acc(input logic [3:0] v);
    @(posedge core_clk);
    acc_val <= v;
  endtask : set_acc

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_carry;
    issue(c4rsb_pkg::OP_SET_CARRY);
    check("carry set", carry_flag, 1'b1);
    check("lines kept", out_lines, 8'h00);
    issue(c4rsb_pkg::OP_CLR_CARRY);
    check("carry clear", carry_flag, 1'b0);
    check("level kept", stack_level, 3'h0);
    $display("test carry done");
  endtask : t_carry

  // Y of 8 must be ignored by both line words
  task automatic t_lines;
    lines_exp = 8'h00;
    for (int y = 0; y <= 8; y++) begin
      @(posedge core_clk);
      y_val <= 4'(y);
      issue(c4rsb_pkg::OP_SET_LINE);
      if (y < 8) lines_exp[y] = 1'b1;
      check("lines after set", out_lines, lines_exp);
    end
    for (int y = 8; y >= 0; y--) begin
      @(posedge core_clk);
      y_val <= 4'(y);
      issue(c4rsb_pkg::OP_CLR_LINE);
      if (y < 8) lines_exp[y] = 1'b0;
      check("lines after clear", out_lines, lines_exp);
    end
    $display("test lines done");
  endtask : t_lines

  task automatic t_returns;
    push(14'h0123);
    push(14'h0456);
    check("level after pushes", stack_level, 3'h2);
    issue(c4rsb_pkg::OP_RET_SUB);
    check("ret pc_load", pc_load, 1'b1);
    check("ret pc", program_counter, 14'h0456);
    check("ret level", stack_level, 3'h1);
    check("ret stall", instr_ready, 1'b0);
    check("ret no skip", skip_pending, 1'b0);
    @(negedge core_clk);
    check("ret pc_load end", pc_load, 1'b0);
    check("ret ready back", instr_ready, 1'b1);
    issue(c4rsb_pkg::OP_RET_SKIP);
    check("rets pc", program_counter, 14'h0123);
    check("rets level", stack_level, 3'h0);
    check("rets stall", instr_ready, 1'b0);
    @(negedge core_clk);
    probe_skip("rets skip", 1'b1);
    $display("test returns done");
  endtask : t_returns

  // Carry and skip come from the block itself, not from ctx_in
  task automatic t_irq;
    logic [20:0] exp;
    exp = {4'h5, 4'hA, 4'h3, 4'hC, 2'h2, 1'b1, 1'b0, 1'b1};
    push(14'h0789);
    issue(c4rsb_pkg::OP_SET_CARRY);
    @(posedge core_clk);
    irq_taken <= 1'b1;
    ctx_in <= {4'h5, 4'hA, 4'h3, 4'hC, 2'h2, 1'b0, 1'b1, 1'b1};
    @(posedge core_clk);
    irq_taken <= 1'b0;
    issue(c4rsb_pkg::OP_CLR_CARRY);
    issue(c4rsb_pkg::OP_RET_IRQ);
    check("reti pc", program_counter, 14'h0789);
    check("reti level", stack_level, 3'h0);
    check("reti no stall", instr_ready, 1'b1);
    check("reti restore", ctx_restore, 1'b1);
    check("reti context", ctx_out, exp);
    check("reti carry", carry_flag, 1'b1);
    @(negedge core_clk);
    check("reti restore end", ctx_restore, 1'b0);
    issue(c4rsb_pkg::OP_CLR_CARRY);
    $display("test interrupt return done");
  endtask : t_irq

  task automatic t_bits;
    for (int j = 0; j < 4; j++) begin
      issue(c4rsb_pkg::OP_SET_BIT + 10'(j));
      check("bit write", mem_we, 1'b1);
      check("bit data", mem_wdata, 4'h2 | (4'h1 << j));
      @(negedge core_clk);
      check("bit write end", mem_we, 1'b0);
    end
    $display("test set bit done");
  endtask : t_bits

  task automatic t_compare;
    set_acc(4'h6);
    issue(c4rsb_pkg::OP_SKIP_IMM);
    issue({c4rsb_pkg::OP_IMM_WORD_HI, 4'h6});
    probe_skip("imm equal", 1'b1);
    issue(c4rsb_pkg::OP_SKIP_IMM);
    issue({c4rsb_pkg::OP_IMM_WORD_HI, 4'h7});
    probe_skip("imm differ", 1'b0);
    set_acc(4'h2);
    issue(c4rsb_pkg::OP_SKIP_MEM);
    probe_skip("mem equal", 1'b1);
    set_acc(4'h3);
    issue(c4rsb_pkg::OP_SKIP_MEM);
    probe_skip("mem differ", 1'b0);
    $display("test compare done");
  endtask : t_compare

  task automatic t_ext(input int k);
    logic [9:0] op;
    op = k ? c4rsb_pkg::OP_EXT1_SKIP : c4rsb_pkg::OP_EXT0_SKIP;
    @(posedge core_clk);
    if (k) ext1_event <= 1'b1; else ext0_event <= 1'b1;
    if (k) ext1_irq_enable <= 1'b1; else ext0_irq_enable <= 1'b1;
    @(posedge core_clk);
    if (k) ext1_event <= 1'b0; else ext0_event <= 1'b0;
    issue(op);
    check("flag kept", k ? ext1_request_flag : ext0_request_flag, 1'b1);
    probe_skip("enabled no skip", 1'b0);
    @(posedge core_clk);
    if (k) ext1_irq_enable <= 1'b0; else ext0_irq_enable <= 1'b0;
    issue(op);
    check("flag cleared", k ? ext1_request_flag : ext0_request_flag, 1'b0);
    probe_skip("flag skip", 1'b1);
    issue(op);
    probe_skip("no flag no skip", 1'b0);
    $display("test external flag %0d done", k);
  endtask : t_ext

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    comparisons = 0;
    nrst = 1'b0;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr_word = 10'h000;
    call_push = 1'b0;
    push_pc = 14'h0000;
    irq_taken = 1'b0;
    ctx_in = '0;
    ext0_event = 1'b0;
    ext1_event = 1'b0;
    ext0_irq_enable = 1'b0;
    ext1_irq_enable = 1'b0;
    acc_val = 4'h9;
    y_val = 4'h0;
    mem_rdata = 4'h2;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check("reset carry", carry_flag, 1'b0);
    check("reset lines", out_lines, c4rsb_pkg::LINES_RST);
    check("reset ready", instr_ready, 1'b1);
    t_carry();
    t_lines();
    t_returns();
    t_irq();
    t_bits();
    t_compare();
    t_ext(0);
    t_ext(1);
    final_report();
  end
endmodule : c4rsb_core_test
